// file: verilog/cdsp_pkg.sv
// Purpose: Shared constants and types for the current converter serial port
// Assumes: 24-bit frames, address byte first, MSB first on the serial lines
// Notes:   Output current is reported in microamps

package cdsp_pkg;

  // Frame layout
  localparam int WORD_W = 24;                    // Bits per frame
  localparam int DATA_W = 16;                    // Data field width
  localparam int ADDR_W = 8;                     // Address field width
  localparam int ADDR_LSB = 16;                  // Address field position

  // Internal register addresses
  localparam logic [7:0] ADDR_NOP  = 8'h00;      // No operation
  localparam logic [7:0] ADDR_DATA = 8'h01;      // Converter code
  localparam logic [7:0] ADDR_READ = 8'h02;      // Readback request
  localparam logic [7:0] ADDR_CTRL = 8'h55;      // Control word

  // Readback selections
  localparam logic [1:0] SEL_STATUS = 2'h0;      // Pin status
  localparam logic [1:0] SEL_DATA   = 2'h1;      // Converter code
  localparam logic [1:0] SEL_CTRL   = 2'h2;      // Control word

  // Control word fields
  localparam int CTRL_RANGE_LSB = 0;             // Range field, two bits
  localparam int CTRL_DAISY_BIT = 3;             // Daisy-chain enable

  // Output ranges
  localparam logic [1:0] RANGE_4_20 = 2'h0;      // 4 mA to 20 mA
  localparam logic [1:0] RANGE_0_20 = 2'h1;      // 0 mA to 20 mA
  localparam logic [1:0] RANGE_0_24 = 2'h2;      // 0 mA to 24 mA

  // Current figures in microamps
  localparam int CUR_W = 15;                     // Current output width
  localparam logic [14:0] CUR_ZERO_UA  = 15'h0000; // 0 mA
  localparam logic [14:0] CUR_4MA_UA   = 15'h0fa0; // 4 mA
  localparam logic [14:0] SPAN_16MA_UA = 15'h3e80; // 16 mA span
  localparam logic [14:0] SPAN_20MA_UA = 15'h4e20; // 20 mA span
  localparam logic [14:0] SPAN_24MA_UA = 15'h5dc0; // 24 mA span

  // Pin sampling
  localparam int SYNC_STAGES = 3;                // Flops per pin input
  localparam int PIN_NUM  = 6;                   // Sampled pins
  localparam int PIN_TEMP = 0;                   // Overtemperature sense
  localparam int PIN_LOOP = 1;                   // Open loop sense
  localparam int PIN_DIN  = 2;                   // Serial input line
  localparam int PIN_CLR  = 3;                   // Clear input
  localparam int PIN_LOAD = 4;                   // Load strobe
  localparam int PIN_LINK = 5;                   // Serial clock

  // Link timing
  localparam longint SYS_CLK_HZ  = 20000000;     // System clock rate
  localparam longint LINK_MAX_HZ = 30000000;     // Fastest serial clock
  localparam int LINK_MIN_PERIOD_CYC =
    int'((SYS_CLK_HZ + LINK_MAX_HZ - 1) / LINK_MAX_HZ); // Cycles per link period

  // Control word
  typedef struct packed {
    logic       daisyEn;                         // Serial out follows shift reg
    logic [1:0] range;                           // Output range
  } cdsp_ctrl_s;

  // Pin inputs, bit order matches PIN_* indices
  typedef struct packed {
    logic linkClk;                               // Serial clock
    logic load;                                  // Load strobe
    logic clear;                                 // Clear input
    logic din;                                   // Serial input line
    logic loopOpen;                              // Open loop detector
    logic overTemp;                              // Overtemperature detector
  } cdsp_pins_s;

endpackage

// file: verilog/cdsp_serial_port.sv
// Purpose: Serial host port of a single-channel current output converter
// Assumes: All pins are asynchronous to sys_clk and are oversampled
// Notes:   Link edges are found by sampling, so the link must run slowly
//
// How it works
// - Serial input shifted on each link rise
// - Link clock rate limited by pin sampling, rises at least three sys_clk cycles apart
// - Load rise copies word to addressed register
// - Data register load updates output current
// - Readback or daisy output changes on falls
// - Clear forces zero scale, 4 or 0 mA
// - Alarm pulled low on open loop, overtemperature

`timescale 1ns/1ps

module cdsp_serial_port
  import cdsp_pkg::*;
(
  input  wire logic                 sys_clk,       // System clock
  input  wire logic                 rst,           // Synchronous reset
  input  wire cdsp_pkg::cdsp_pins_s pinsIn,        // Raw pin levels
  output logic                      serialOutO,    // Serial out level
  output logic                      serialOutOe,   // Serial out drive enable
  output logic                      alarmO,        // Alarm level, always low
  output logic                      alarmOe,       // Alarm pull-down enable
  output logic [cdsp_pkg::CUR_W-1:0]  outCurrentUa,  // Output current, microamps
  output logic [cdsp_pkg::DATA_W-1:0] dacCode        // Active converter code
);
  import cdsp_pkg::*;

  // Synchroniser chains and filtered levels
  logic [PIN_NUM-1:0] syncA;                 // First stage
  logic [PIN_NUM-1:0] syncB;                 // Second stage
  logic [PIN_NUM-1:0] syncC;                 // Third stage
  logic [PIN_NUM-1:0] pinLvl;                // Agreed level
  logic [PIN_NUM-1:0] pinPrev;               // Agreed level one cycle back
  logic [PIN_NUM-1:0] next_pinLvl;           // Next agreed level

  // Shift and internal registers
  logic [WORD_W-1:0]  inShift;               // Input shift register
  logic [DATA_W-1:0]  outShift;              // Readback shift register
  logic [DATA_W-1:0]  dataReg;               // Converter code register
  cdsp_ctrl_s         ctrl;                  // Control register
  logic               rbActive;              // Readback frame in progress

  // Decoded events
  logic               linkRise;              // Link clock rising
  logic               linkFall;              // Link clock falling
  logic               loadRise;              // Load strobe rising
  logic [ADDR_W-1:0]  wordAddr;              // Address of held word
  logic [DATA_W-1:0]  wordData;              // Data of held word
  logic               outUsed;               // Serial out in use

  // Current for a code in a range
  function automatic logic [CUR_W-1:0] codeToUa(input logic [1:0] rng,
                                                 input logic [DATA_W-1:0] code);
    logic [31:0] span;
    logic [31:0] prod;
    span = (rng == RANGE_4_20) ? 32'(SPAN_16MA_UA) :
           (rng == RANGE_0_20) ? 32'(SPAN_20MA_UA) : 32'(SPAN_24MA_UA);
    prod = 32'(code) * span;
    return zeroUa(rng) + prod[DATA_W +: CUR_W];
  endfunction

  // Zero-scale current of a range
  function automatic logic [CUR_W-1:0] zeroUa(input logic [1:0] rng);
    return (rng == RANGE_4_20) ? CUR_4MA_UA : CUR_ZERO_UA;
  endfunction

  // Readback value for a selection
  function automatic logic [DATA_W-1:0] readSel(input logic [1:0] sel,
                                                input logic [DATA_W-1:0] code,
                                                input cdsp_ctrl_s c,
                                                input logic [PIN_NUM-1:0] lvl);
    logic [DATA_W-1:0] v;
    v = '0;
    case (sel)
      SEL_DATA:   v = code;
      SEL_CTRL:   v[$bits(cdsp_ctrl_s)-1:0] = c;
      SEL_STATUS:
      begin
        v[PIN_TEMP] = lvl[PIN_TEMP];
        v[PIN_LOOP] = lvl[PIN_LOOP];
        v[PIN_CLR]  = lvl[PIN_CLR];
      end
      default:    v = '0;
    endcase
    return v;
  endfunction

  // Three-stage sampling of every pin
  genvar gi;
  generate
    for (gi = 0; gi < PIN_NUM; gi = gi + 1)
    begin : g_sync
      // Stages move every cycle
      always_ff @(posedge sys_clk)
      begin
        if (rst)
        begin
          syncA[gi] <= 1'b0;
          syncB[gi] <= 1'b0;
          syncC[gi] <= 1'b0;
        end
        else
        begin
          syncA[gi] <= pinsIn[gi];
          syncB[gi] <= syncA[gi];
          syncC[gi] <= syncB[gi];
        end
      end

      // Level changes only when stages two and three agree
      always_comb
      begin
        next_pinLvl[gi] = (syncB[gi] == syncC[gi]) ? syncC[gi] : pinLvl[gi];
      end
    end
  endgenerate

  // Agreed levels and their history
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pinLvl  <= '0;
      pinPrev <= '0;
    end
    else
    begin
      pinLvl  <= next_pinLvl;
      pinPrev <= pinLvl;
    end
  end

  // Edge and field decode
  assign linkRise = pinLvl[PIN_LINK] & ~pinPrev[PIN_LINK];
  assign linkFall = ~pinLvl[PIN_LINK] & pinPrev[PIN_LINK];
  assign loadRise = pinLvl[PIN_LOAD] & ~pinPrev[PIN_LOAD];
  assign wordAddr = inShift[ADDR_LSB +: ADDR_W];
  assign wordData = inShift[DATA_W-1:0];
  assign outUsed  = ctrl.daisyEn | rbActive;

  // Input shift register, MSB first
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      inShift <= '0;
    else if (linkRise)                       // Sample on link rise
      inShift <= {inShift[WORD_W-2:0], pinLvl[PIN_DIN]};
  end

  // Internal registers loaded on load strobe rise
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dataReg <= '0;
      ctrl    <= '0;
    end
    else if (loadRise)
    begin
      if (wordAddr == ADDR_DATA)             // Data field to data register
        dataReg <= wordData;
      else if (wordAddr == ADDR_CTRL)        // Control register
      begin
        ctrl.range   <= wordData[CTRL_RANGE_LSB +: 2];
        ctrl.daisyEn <= wordData[CTRL_DAISY_BIT];
      end
    end
  end

  // Readback frame setup and shifting
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rbActive <= 1'b0;
      outShift <= '0;
    end
    else if (loadRise)
    begin
      rbActive <= (wordAddr == ADDR_READ);   // Load rise starts readback on ADDR_READ, else ends it
      outShift <= readSel(wordData[1:0], dataReg, ctrl, pinLvl);
    end
    else if (linkFall && rbActive)
      outShift <= {outShift[DATA_W-2:0], 1'b0};
  end

  // Serial output line
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      serialOutO  <= 1'b0;
      serialOutOe <= 1'b0;
    end
    else
    begin
      serialOutOe <= outUsed;                // Released otherwise
      if (linkFall && ctrl.daisyEn)          // Daisy: shift reg MSB
        serialOutO <= inShift[WORD_W-1];
      else if (linkFall && rbActive)         // Readback bit out
        serialOutO <= outShift[DATA_W-1];
    end
  end

  // Output current, cleared to zero scale while clear is high
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      outCurrentUa <= '0;
      dacCode      <= '0;
    end
    else if (pinLvl[PIN_CLR])                // Zero scale
    begin
      outCurrentUa <= zeroUa(ctrl.range);
      dacCode      <= '0;
    end
    else                                     // Follows data register
    begin
      outCurrentUa <= codeToUa(ctrl.range, dataReg);
      dacCode      <= dataReg;
    end
  end

  // Open-drain alarm
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      alarmO  <= 1'b0;
      alarmOe <= 1'b0;
    end
    else
    begin
      alarmO  <= 1'b0;
      alarmOe <= pinLvl[PIN_LOOP] | pinLvl[PIN_TEMP]; // Pull low on fault
    end
  end

  // Checks
  a_shift_sample: assert property (@(posedge sys_clk) disable iff (rst)
    linkRise |=> inShift[0] == $past(pinLvl[PIN_DIN]))
    else $error("input bit not sampled on link rise");

  a_link_spacing: assert property (@(posedge sys_clk) disable iff (rst)
    linkRise |=> !linkRise ##1 !linkRise)
    else $error("link rises closer than the sampler allows");

  a_load_data: assert property (@(posedge sys_clk) disable iff (rst)
    (loadRise && wordAddr == ADDR_DATA) |=> dataReg == $past(wordData))
    else $error("data register not loaded from shift register");

  a_current_update: assert property (@(posedge sys_clk) disable iff (rst)
    (loadRise && wordAddr == ADDR_DATA && !pinLvl[PIN_CLR]) ##1 !pinLvl[PIN_CLR]
      |=> dacCode == $past(wordData, 2))
    else $error("output not updated by data load");

  a_out_on_fall: assert property (@(posedge sys_clk) disable iff (rst)
    (linkFall && rbActive && !ctrl.daisyEn) |=> serialOutO == $past(outShift[DATA_W-1]))
    else $error("readback bit not driven on link fall");

  a_clear_zero: assert property (@(posedge sys_clk) disable iff (rst)
    pinLvl[PIN_CLR] |=> outCurrentUa == zeroUa($past(ctrl.range)) && dacCode == '0)
    else $error("clear did not force zero scale");

  a_alarm_pull: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 alarmOe == $past(pinLvl[PIN_LOOP] | pinLvl[PIN_TEMP]))
    else $error("alarm does not follow fault detectors");

  a_out_released: assert property (@(posedge sys_clk) disable iff (rst)
    (!ctrl.daisyEn && !rbActive) |=> !serialOutOe)
    else $error("serial out driven while unused");

endmodule

// file: dv/cdsp_host_model.sv
// Purpose: Host side of the converter serial link
// Assumes: Link clock idles low between frames, 400 ns period
// Notes:   Serial out is sampled in the middle of each high phase;
//          a released line reads as the inverse of its last level
`timescale 1ns/1ps
module cdsp_host_model (
  input  wire logic sys_clk,     // System clock
  input  wire logic serialOutO,  // Serial out level from the port
  input  wire logic serialOutOe, // Serial out drive enable
  output logic      linkClk,     // Serial clock
  output logic      din,         // Serial input line
  output logic      load         // Load strobe
);
  // Idle levels
  initial
  begin
    linkClk = 1'b0;
    din = 1'b0;
    load = 1'b0;
  end
  // Whole system cycles, then step off the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // One frame, MSB first, collecting serial out bits
  task automatic send_word(input logic [23:0] w, output logic [23:0] rx);
    cyc(2);
    for (int i = 23; i >= 0; i--)
    begin
      din = w[i];              // Held across the whole rise
      cyc(4);
      linkClk = 1'b1;          // 400 ns period, well under 30 MHz
      cyc(2);
      rx = {rx[22:0], serialOutOe ? serialOutO : ~serialOutO};
      cyc(2);
      linkClk = 1'b0;
    end
    din = ~din;                // Input line left at inverse of last bit
  endtask
  // Load strobe pulse, long enough to be seen
  task automatic pulse_load();
    cyc(2);
    load = 1'b1;
    cyc(6);
    load = 1'b0;
    cyc(8);
  endtask
endmodule

// file: dv/tb.sv
// Purpose: Self-checking bench for the converter serial port
// Assumes: 20 MHz system clock, host model drives the link
// Notes:   Expected current worked out from range and code
`timescale 1ns/1ps
module tb;
  import cdsp_pkg::*;
  logic              sys_clk = 1'b0;  // System clock
  logic              rst = 1'b1;      // Synchronous reset
  logic              clear = 1'b0;    // Clear pin
  logic              loopOpen = 1'b0; // Open loop sense
  logic              overTemp = 1'b0; // Overtemperature sense
  logic              linkClk, din, load, serialOutO, serialOutOe, alarmO, alarmOe;
  logic [CUR_W-1:0]  outCurrentUa;    // Output current
  logic [DATA_W-1:0] dacCode;         // Active code
  logic [23:0]       rx;              // Serial out of last frame
  cdsp_pins_s        pinsIn;          // Pin bundle
  int                miscompares = 0;
  int                comparisons = 0;
  assign pinsIn = {linkClk, load, clear, din, loopOpen, overTemp};
  always #25 sys_clk = ~sys_clk;
  cdsp_serial_port cdsp_serial_port_inst (.sys_clk, .rst, .pinsIn, .serialOutO,
    .serialOutOe, .alarmO, .alarmOe, .outCurrentUa, .dacCode);
  cdsp_host_model cdsp_host_model_inst (.sys_clk, .serialOutO, .serialOutOe, .linkClk, .din,
    .load);
  // Zero scale plus scaled code
  function automatic logic [14:0] exp_cur(input logic [1:0] rng, input logic [15:0] c);
    logic [31:0] span;
    span = (rng == RANGE_4_20) ? SPAN_16MA_UA : (rng == RANGE_0_20) ? SPAN_20MA_UA
         : SPAN_24MA_UA;
    return ((rng == RANGE_4_20) ? CUR_4MA_UA : CUR_ZERO_UA) + 15'((32'(c) * span) >> 16);
  endfunction
  task automatic fail(input string what);
    miscompares++;
    $display("Error at %0t: %s", $time, what);
  endtask
  // Code and current together
  task automatic check_out(input logic [15:0] c, input logic [14:0] cur, input string what);
    comparisons += 2;
    if (dacCode !== c || outCurrentUa !== cur)
      fail(what);
  endtask
  task automatic check_bits(input logic [15:0] got, exp, input string what);
    comparisons++;
    if (got !== exp)
      fail(what);
  endtask
  task automatic check_flag(input logic got, exp, input string what);
    comparisons++;
    if (got !== exp)
      fail(what);
  endtask
  task automatic cyc(input int n);
    cdsp_host_model_inst.cyc(n);
  endtask
  // Frame plus load
  task automatic xfer(input logic [7:0] a, input logic [15:0] d);
    cdsp_host_model_inst.send_word({a, d}, rx);
    cdsp_host_model_inst.pulse_load();
  endtask
  task automatic t_reset();
    check_out(16'h0000, CUR_4MA_UA, "reset outputs");
    check_flag(serialOutOe, 1'b0, "serial out driven at idle");
    check_flag(alarmOe, 1'b0, "alarm without fault");
    $display("Test reset done");
  endtask
  task automatic t_write();
    logic [15:0] codes[3] = '{16'hffff, 16'h0001, 16'ha5c3};
    foreach (codes[i])
    begin
      xfer(ADDR_DATA, codes[i]);
      check_out(codes[i], exp_cur(RANGE_4_20, codes[i]), "data load");
    end
    xfer(8'h33, 16'h1234);
    check_out(16'ha5c3, exp_cur(RANGE_4_20, 16'ha5c3), "unused address");
    $display("Test write done");
  endtask
  task automatic t_range();
    for (int r = 0; r < 4; r++)
    begin
      xfer(ADDR_CTRL, 16'(r));
      check_out(16'ha5c3, exp_cur(2'(r), 16'ha5c3), "range change");
    end
    $display("Test range done");
  endtask
  task automatic t_clear();
    clear = 1'b1;
    cyc(6);
    check_out(16'h0000, CUR_ZERO_UA, "clear 0 mA");
    xfer(ADDR_CTRL, 16'h0000);
    xfer(ADDR_DATA, 16'h4000);
    check_out(16'h0000, CUR_4MA_UA, "clear 4 mA");
    clear = 1'b0;
    cyc(6);
    check_out(16'h4000, exp_cur(RANGE_4_20, 16'h4000), "clear released");
    $display("Test clear done");
  endtask
  task automatic t_readback();
    xfer(ADDR_READ, 16'(SEL_DATA));
    check_flag(serialOutOe, 1'b1, "readback drive");
    cdsp_host_model_inst.send_word(24'h000000, rx);
    check_bits(rx[22:7], 16'h4000, "data readback");
    xfer(ADDR_CTRL, 16'h0001);
    xfer(ADDR_READ, 16'(SEL_CTRL));
    cdsp_host_model_inst.send_word(24'h000000, rx);
    check_bits(rx[22:7], 16'h0001, "control readback");
    loopOpen = 1'b1;
    xfer(ADDR_READ, 16'(SEL_STATUS));
    cdsp_host_model_inst.send_word(24'h000000, rx);
    check_bits(rx[22:7], 16'h0002, "status readback");
    loopOpen = 1'b0;
    cdsp_host_model_inst.pulse_load();
    check_flag(serialOutOe, 1'b0, "released after readback");
    $display("Test readback done");
  endtask
  task automatic t_daisy();
    xfer(ADDR_CTRL, 16'h0008);
    check_flag(serialOutOe, 1'b1, "daisy drive");
    cdsp_host_model_inst.send_word(24'h5a3c96, rx);
    cdsp_host_model_inst.send_word(24'h000000, rx);
    check_bits(rx[15:0], 16'h3c96, "daisy pass-through");
    cdsp_host_model_inst.pulse_load();
    xfer(ADDR_CTRL, 16'h0000);
    check_flag(serialOutOe, 1'b0, "released after daisy");
    $display("Test daisy done");
  endtask
  task automatic t_alarm();
    for (int k = 0; k < 2; k++)
    begin
      {loopOpen, overTemp} = k ? 2'b10 : 2'b01;
      cyc(6);
      check_flag(alarmOe, 1'b1, "alarm on fault");
      check_flag(alarmO, 1'b0, "alarm level");
      {loopOpen, overTemp} = 2'b00;
      cyc(6);
      check_flag(alarmOe, 1'b0, "alarm released");
    end
    $display("Test alarm done");
  endtask
  task automatic tally_and_finish();
    $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1 rst = 1'b0;
    cyc(6);
    t_reset();
    t_write();
    t_range();
    t_clear();
    t_readback();
    t_daisy();
    t_alarm();
    tally_and_finish();
  end
  // Hang guard
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule
